// ==== pkg/ldm_params.svh ====
// constants for the led matrix dimming and fault block
// assumes inclusion by the design file only
`ifndef LDM_PARAMS_SVH
`define LDM_PARAMS_SVH
`define LDM_NUM_SINKS      18
`define LDM_NUM_LINES      11
`define LDM_CC_FULL        7'h7f
`define LDM_DC_FULL        8'hff
`define LDM_PEAK_RESET     3'h3
`define LDM_CC_RESET       7'h40
`define LDM_DC_RESET       8'h80
`define LDM_BRI_RESET      8'hff
`define LDM_CLEAR_CODE     8'h0f
`define LDM_OPEN_MIN8      16'h0019
`define LDM_OPEN_MIN16     16'h1900
`define LDM_FAULT_SUBS     3'h4
`define LDM_OSC_MHZ        32
`define LDM_PWM_HI_KHZ     125
`define LDM_PHASE_NS       125
`define LDM_CLK_NS         40
`endif

// ==== pkg/ldm_pkg.sv ====
// types for the led matrix dimming and fault block
// assumes ldm_params.svh sits in the include path
package ldm_pkg;
  typedef enum logic [1:0] {
    LDM_MODE_DIRECT = 2'b00,
    LDM_MODE_FRAME8 = 2'b01,
    LDM_MODE_FRAME16 = 2'b10
  } ldm_mode_e;
  typedef enum logic [1:0] {
    LDM_GRP_NONE  = 2'b00,
    LDM_GRP_ONE   = 2'b01,
    LDM_GRP_TWO   = 2'b10,
    LDM_GRP_THREE = 2'b11
  } ldm_grp_e;
  typedef enum logic [1:0] {
    LDM_ST_BLANK = 2'b00,
    LDM_ST_SHIFT = 2'b01,
    LDM_ST_PWM   = 2'b10
  } ldm_state_e;
endpackage

// ==== src/ldm_dimming.sv ====
// per-dot dimming engine with fault flags for an 18 sink scanned matrix
// assumes dot data arrive one dot per write strobe, synchronous to core_clk
// Operation
// - seven bit colour code scales sink current
// - sink index modulo three picks colour group
// - eight bit per-dot current code held
// - current is peak times cc times dc, divided by 128
// - each dot owns an 8 or 16 bit duty
// - two bit selector picks dot pwm group
// - final duty is individual times group times global
// - pwm runs at 125kHz or 62.5kHz
// - pwm timing counted in 40ns core_clk cycles
// - optional three phase turn-on stagger of 4 core_clk cycles (160ns)
// - optional two tick (two core_clk cycle) sink-on delay after line
// - gamma or linear duty scale selectable
// - per-dot on/off bit gates the dot
// - mode one applies 8-bit dot data immediately
// - modes two and three apply frame on sync
// - open fault after four low sub-periods, duty qualified
// - writing 0fh clears every open flag not set in that same cycle
// - open cutoff disables faulted sink on its line
// - short fault after four high sub-periods, duty qualified
// - writing 0fh clears every short flag not set in that same cycle
// - short cutoff disables upside deghost on line
// - three bit peak code, reset code three
// - framed modes take peak code across chip enable
`timescale 1ns/100ps
`include "ldm_params.svh"
module ldm_dimming #(
  parameter int NS = `LDM_NUM_SINKS,
  parameter int NL = `LDM_NUM_LINES,
  parameter int ND = NS * NL
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire ldm_pkg::ldm_mode_e     refresh_mode,
  input  wire logic                   chip_enable,
  input  wire logic                   pwm_freq_low,
  input  wire logic                   phase_shift_enable,
  input  wire logic                   sink_on_shift_enable,
  input  wire logic                   gamma_scale_enable,
  input  wire logic                   open_channel_cutoff_enable,
  input  wire logic                   shorted_line_deghost_cutoff_enable,
  input  wire logic                   upside_deghost_enable,
  input  wire logic [2:0]             peak_current_code,
  input  wire logic [6:0]             color_one_current_code,
  input  wire logic [6:0]             color_two_current_code,
  input  wire logic [6:0]             color_three_current_code,
  input  wire logic [7:0]             global_duty,
  input  wire logic [7:0]             group_one_duty,
  input  wire logic [7:0]             group_two_duty,
  input  wire logic [7:0]             group_three_duty,
  input  wire logic                   dot_write,
  input  wire logic [7:0]             dot_index,
  input  wire logic [15:0]            dot_duty,
  input  wire logic [7:0]             per_dot_current_code,
  input  wire ldm_pkg::ldm_grp_e      dot_group_select,
  input  wire logic                   dot_on,
  input  wire logic                   vsync,
  input  wire logic [7:0]             open_flag_clear,
  input  wire logic                   open_flag_clear_write,
  input  wire logic [7:0]             short_flag_clear,
  input  wire logic                   short_flag_clear_write,
  input  wire logic [NS-1:0]          open_led_detect,
  input  wire logic [NS-1:0]          shorted_led_detect,
  output logic [3:0]                  scan_line,
  output logic [NS-1:0]               sink_enable,
  output logic [NS*16-1:0]            sink_current,
  output logic                        upside_deghost_active,
  output logic                        any_open_fault_flag,
  output logic                        any_short_fault_flag,
  output logic [ND-1:0]               dot_open_flags,
  output logic [ND-1:0]               dot_short_flags,
  output logic [2:0]                  peak_code_active
);
  import ldm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // timing: the 32MHz reference is folded into core_clk tick counts
  localparam int TICK_NS   = 1000 / `LDM_OSC_MHZ;
  localparam int PWM_HI_NS = 1000000 / `LDM_PWM_HI_KHZ;
  localparam int PWM_CYC   = (PWM_HI_NS + `LDM_CLK_NS - 1) / `LDM_CLK_NS;
  localparam int PH_CYC_R  = (`LDM_PHASE_NS + `LDM_CLK_NS - 1) / `LDM_CLK_NS;
  localparam int PH_CYC    = (PH_CYC_R < 1) ? 1 : PH_CYC_R;
  localparam int SH_CYC    = (TICK_NS * 2 + `LDM_CLK_NS - 1) / `LDM_CLK_NS;
  localparam int SHIFT_CYC = (SH_CYC < 1) ? 1 : SH_CYC;
  localparam int BLANK_CYC = 2 * PH_CYC;

  ////////////////////////////////////////////////////////////////////////////
  // dot memories: pending set written by host, live set drives sinks
  logic [15:0] duty_pend [ND];
  logic [15:0] duty_live [ND];
  logic [7:0]  dc_mem    [ND];
  logic [1:0]  grp_mem   [ND];
  logic [ND-1:0] on_pend;
  logic [ND-1:0] on_live;
  logic vsync_reg;
  logic sync_pulse;
  logic framed;

  assign framed = (refresh_mode != LDM_MODE_DIRECT);
  assign sync_pulse = vsync & ~vsync_reg;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      vsync_reg <= 1'b0;
    end else begin
      vsync_reg <= vsync;
    end
  end

  // duty, current and group memories are not reset; the host loads them before enabling
  always_ff @(posedge core_clk) begin
    if (dot_write && dot_index < ND) begin
      duty_pend[dot_index] <= dot_duty;
      dc_mem[dot_index]    <= per_dot_current_code;
      grp_mem[dot_index]   <= dot_group_select;
      if (!framed) begin
        duty_live[dot_index] <= {8'h00, dot_duty[7:0]};
      end
    end
    if (framed && sync_pulse) begin
      for (int i = 0; i < ND; i++) begin
        duty_live[i] <= duty_pend[i];
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      on_pend <= '0;
      on_live <= '0;
    end else begin
      if (dot_write && dot_index < ND) begin
        on_pend[dot_index] <= dot_on;
        if (!framed) begin
          on_live[dot_index] <= dot_on;
        end
      end
      if (framed && sync_pulse) begin
        on_live <= on_pend;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // peak current code, taken across chip enable in framed modes
  logic [2:0] peak_hold_reg;
  logic       chip_en_reg;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      peak_hold_reg    <= `LDM_PEAK_RESET;
      peak_code_active <= `LDM_PEAK_RESET;
      chip_en_reg      <= 1'b0;
    end else begin
      chip_en_reg <= chip_enable;
      // hold tracks the code in any mode while off, so a mode change is safe
      if (!chip_enable) begin
        peak_hold_reg <= peak_current_code;
      end
      if (!framed) begin
        peak_code_active <= peak_current_code;
      end else if (chip_enable && !chip_en_reg) begin
        peak_code_active <= peak_hold_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line scan sequencer
  ldm_state_e  state_reg;
  logic [15:0] cnt_reg;
  logic [7:0]  slot_reg;
  logic        sub_end;
  logic [15:0] pwm_len;

  // the low frequency doubles the active window
  assign pwm_len = pwm_freq_low ? 16'(2 * PWM_CYC) : 16'(PWM_CYC);
  assign sub_end = (state_reg == LDM_ST_PWM)
                   && (cnt_reg >= pwm_len - 16'h0001)
                   && (scan_line == 4'(NL - 1));

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= LDM_ST_BLANK;
      cnt_reg   <= '0;
      scan_line <= '0;
    end else if (!chip_enable) begin
      state_reg <= LDM_ST_BLANK;
      cnt_reg   <= '0;
      scan_line <= '0;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
      case (state_reg)
        LDM_ST_BLANK: begin
          if (cnt_reg == 16'(BLANK_CYC - 1)) begin
            cnt_reg   <= '0;
            state_reg <= sink_on_shift_enable ? LDM_ST_SHIFT : LDM_ST_PWM;
          end
        end
        LDM_ST_SHIFT: begin
          if (cnt_reg == 16'(SHIFT_CYC - 1)) begin
            cnt_reg   <= '0;
            state_reg <= LDM_ST_PWM;
          end
        end
        default: begin
          // window may shrink mid-line; >= avoids a wrap of the counter
          if (cnt_reg >= pwm_len - 16'h0001) begin
            cnt_reg   <= '0;
            state_reg <= LDM_ST_BLANK;
            scan_line <= (scan_line == 4'(NL - 1)) ? 4'h0
                         : scan_line + 4'h1;
          end
        end
      endcase
    end
  end

  assign slot_reg = 8'(cnt_reg * 256 / pwm_len);

  ////////////////////////////////////////////////////////////////////////////
  // per-sink duty, current and fault logic
  function automatic logic [7:0] gamma8(input logic [7:0] x);
    logic [15:0] sq;
    sq = x * x;
    gamma8 = sq[15:8];                      // square law stands in for gamma
  endfunction

  logic [ND-1:0] open_set;
  logic [ND-1:0] short_set;
  logic [NL-1:0] short_line;
  logic [1:0]    open_cnt  [ND];
  logic [1:0]    short_cnt [ND];

  genvar s;
  generate
    for (s = 0; s < NS; s++) begin : g_sink
      logic [7:0]  idx;
      logic [15:0] ind;
      logic [7:0]  ind8;
      logic [7:0]  grp;
      logic [23:0] fin;
      logic [6:0]  cc;
      logic [22:0] cur;
      logic [7:0]  start;
      logic        act;
      assign idx = 8'(scan_line * NS + s);
      assign ind = duty_live[idx];
      assign ind8 = (refresh_mode == LDM_MODE_FRAME16) ? ind[15:8] : ind[7:0];
      always_comb begin
        case (ldm_grp_e'(grp_mem[idx]))
          LDM_GRP_ONE:   grp = group_one_duty;
          LDM_GRP_TWO:   grp = group_two_duty;
          LDM_GRP_THREE: grp = group_three_duty;
          default:       grp = 8'hff;
        endcase
      end
      assign fin = (gamma_scale_enable ? 24'(gamma8(ind8)) : 24'(ind8))
                   * grp * global_duty;
      assign cc = (s % 3 == 0) ? color_one_current_code
                : (s % 3 == 1) ? color_two_current_code
                : color_three_current_code;
      assign cur = 23'(peak_code_active) * cc * dc_mem[idx];
      assign start = phase_shift_enable ? 8'((s % 3) * PH_CYC) : 8'h00;
      assign act = (state_reg == LDM_ST_PWM) && on_live[idx]
                   && (cnt_reg >= 16'(start))
                   && (slot_reg < fin[23:16])
                   && !(open_channel_cutoff_enable && dot_open_flags[idx]);
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          sink_enable[s] <= 1'b0;
          sink_current[s*16 +: 16] <= '0;
        end else begin
          sink_enable[s] <= act;
          sink_current[s*16 +: 16] <= cur[22:7];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // fault counting per dot at sub-period end
  genvar d;
  generate
    for (d = 0; d < ND; d++) begin : g_dot
      logic qual;
      logic [15:0] dv;
      assign dv = duty_live[d];
      assign qual = (refresh_mode == LDM_MODE_FRAME16)
                    ? (dv >= `LDM_OPEN_MIN16)
                    : (dv[7:0] >= `LDM_OPEN_MIN8);
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          open_cnt[d]  <= '0;
          short_cnt[d] <= '0;
        end else if (sub_end) begin
          open_cnt[d]  <= (qual && open_led_detect[d % NS])
                          ? ((open_cnt[d] == 2'h3) ? 2'h3 : open_cnt[d] + 2'h1)
                          : 2'h0;
          short_cnt[d] <= (qual && shorted_led_detect[d % NS])
                          ? ((short_cnt[d] == 2'h3) ? 2'h3
                             : short_cnt[d] + 2'h1)
                          : 2'h0;
        end
      end
      // detector is sampled only at the last line's sub-period end, for dots of every line
      assign open_set[d] = sub_end && qual && open_led_detect[d % NS]
                           && open_cnt[d] == 2'(`LDM_FAULT_SUBS - 1);
      assign short_set[d] = sub_end && qual && shorted_led_detect[d % NS]
                            && short_cnt[d] == 2'(`LDM_FAULT_SUBS - 1);
    end
  endgenerate

  // set wins over clear so a fault landing on the clear is kept
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dot_open_flags  <= '0;
      dot_short_flags <= '0;
    end else begin
      if (open_flag_clear_write && open_flag_clear == `LDM_CLEAR_CODE) begin
        dot_open_flags <= open_set;
      end else begin
        dot_open_flags <= dot_open_flags | open_set;
      end
      if (short_flag_clear_write && short_flag_clear == `LDM_CLEAR_CODE) begin
        dot_short_flags <= short_set;
      end else begin
        dot_short_flags <= dot_short_flags | short_set;
      end
    end
  end

  assign any_open_fault_flag  = |dot_open_flags;
  assign any_short_fault_flag = |dot_short_flags;

  for (genvar l = 0; l < NL; l++) begin : g_line
    assign short_line[l] = |dot_short_flags[l*NS +: NS];
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      upside_deghost_active <= 1'b0;
    end else begin
      upside_deghost_active <= upside_deghost_enable
        && (state_reg == LDM_ST_BLANK)
        && !(shorted_line_deghost_cutoff_enable
             && short_line[scan_line]);
    end
  end
endmodule

// ==== verification/ldm_dimming_asserts.sv ====
// checker: port relations of the dimming block
// assumes binding onto every ldm_dimming instance
`timescale 1ns/100ps
module ldm_dimming_asserts #(
  parameter int NS = 18,
  parameter int ND = 198
) (
  input wire logic               core_clk,
  input wire logic               rst,
  input wire ldm_pkg::ldm_mode_e refresh_mode,
  input wire logic               chip_enable,
  input wire logic [2:0]         peak_current_code,
  input wire logic [7:0]         open_flag_clear,
  input wire logic               open_flag_clear_write,
  input wire logic [7:0]         short_flag_clear,
  input wire logic               short_flag_clear_write,
  input wire logic [NS-1:0]      open_led_detect,
  input wire logic [NS-1:0]      shorted_led_detect,
  input wire logic               any_open_fault_flag,
  input wire logic               any_short_fault_flag,
  input wire logic [ND-1:0]      dot_open_flags,
  input wire logic [ND-1:0]      dot_short_flags,
  input wire logic [2:0]         peak_code_active
);
  import ldm_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic oclr;
  logic sclr;
  assign oclr = open_flag_clear_write && open_flag_clear == 8'h0f;
  assign sclr = short_flag_clear_write && short_flag_clear == 8'h0f;
  ////////////////////////////////////////////////////////////////////////////
  a_peak_direct_follow: assert property (
    (refresh_mode == LDM_MODE_DIRECT && $stable(peak_current_code))[*3]
    |-> peak_code_active == peak_current_code) else $error("peak lag");
  // two cycles of margin after the enable rise, where the new code lands
  a_peak_framed_hold: assert property (
    refresh_mode != LDM_MODE_DIRECT && $stable(refresh_mode) && chip_enable
    && $past(chip_enable) && $past(chip_enable, 2)
    |-> $stable(peak_code_active)) else $error("peak moved while on");
  a_open_any_or: assert property (
    any_open_fault_flag == (|dot_open_flags)) else $error("open summary");
  a_short_any_or: assert property (
    any_short_fault_flag == (|dot_short_flags)) else $error("short summary");
  a_open_clear_all: assert property (
    oclr && open_led_detect == '0 |=> dot_open_flags == '0)
    else $error("open clear missed");
  a_short_clear_all: assert property (
    sclr && shorted_led_detect == '0 |=> dot_short_flags == '0)
    else $error("short clear missed");
  a_open_flags_hold: assert property (
    !oclr |=> (dot_open_flags & $past(dot_open_flags))
    == $past(dot_open_flags)) else $error("open flag dropped");
  a_short_flags_hold: assert property (
    !sclr |=> (dot_short_flags & $past(dot_short_flags))
    == $past(dot_short_flags)) else $error("short flag dropped");
  a_open_needs_detect: assert property (
    $rose(any_open_fault_flag) |-> $past(|open_led_detect))
    else $error("open flag without detect");
  a_short_needs_detect: assert property (
    $rose(any_short_fault_flag) |-> $past(|shorted_led_detect))
    else $error("short flag without detect");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind ldm_dimming ldm_dimming_asserts #(.NS(NS), .ND(ND)) u_chk (
  .core_clk, .rst, .refresh_mode, .chip_enable, .peak_current_code,
  .open_flag_clear, .open_flag_clear_write, .short_flag_clear,
  .short_flag_clear_write, .open_led_detect, .shorted_led_detect,
  .any_open_fault_flag, .any_short_fault_flag, .dot_open_flags,
  .dot_short_flags, .peak_code_active);

// ==== verification/ldm_host_model.sv ====
// host model: writes every dot, pulses frame sync
// assumes it shares core_clk with the block
`timescale 1ns/100ps
module ldm_host_model (
  input wire logic          core_clk,
  output logic              dot_write,
  output logic [7:0]        dot_index,
  output logic [15:0]       dot_duty,
  output logic [7:0]        per_dot_current_code,
  output ldm_pkg::ldm_grp_e dot_group_select,
  output logic              dot_on,
  output logic              vsync
);
  import ldm_pkg::*;
  localparam int SYNC_HI = 4;
  initial begin
    {dot_write, dot_index, dot_duty, per_dot_current_code} = '0;
    dot_group_select = LDM_GRP_NONE;
    {dot_on, vsync} = '0;
  end
  // index 198 lies off the matrix; the block must drop it
  task automatic write_all(input logic [15:0] duty, input logic rnd,
                           input logic [7:0] dc);
    for (int i = 0; i < 199; i++) begin
      @(posedge core_clk);
      dot_write            <= 1'b1;
      dot_index            <= 8'(i);
      dot_duty             <= i == 198 ? 16'h0 :
                              rnd ? 16'(25 + $urandom % 231) : duty;
      per_dot_current_code <= dc;
      dot_group_select     <= ldm_grp_e'(i % 4);
      dot_on               <= i != 198;
    end
    @(posedge core_clk);
    dot_write <= 1'b0;
    dot_index <= ~dot_index; // idle lines carry junk, not the last dot
    dot_duty  <= ~dot_duty;
  endtask
  task automatic sync_pulse();
    @(posedge core_clk);
    vsync <= 1'b1;
    repeat (SYNC_HI) @(posedge core_clk);
    vsync <= 1'b0;
  endtask
endmodule

// ==== verification/tb_led_matrix_dimming_and_fault_logic.sv ====
// self-checking bench for the dimming and fault block
// assumes ldm_pkg compiled first, checker bound
`timescale 1ns/100ps
module tb_led_matrix_dimming_and_fault_logic;
  import ldm_pkg::*;
  typedef struct {int kind; int idx; logic [15:0] val;} ldm_note_s;
  localparam int SUB = 2400; // eleven lines of about 208 cycles
  logic         core_clk, rst, chip_enable, pwm_freq_low, vsync, dot_on;
  ldm_mode_e    refresh_mode;
  logic         phase_shift_enable, sink_on_shift_enable;
  logic         gamma_scale_enable, upside_deghost_enable;
  logic         open_channel_cutoff_enable, upside_deghost_active;
  logic         shorted_line_deghost_cutoff_enable, dot_write;
  logic [2:0]   peak_current_code, peak_code_active;
  logic [6:0]   color_one_current_code, color_two_current_code;
  logic [6:0]   color_three_current_code;
  logic [7:0]   global_duty, group_one_duty, group_two_duty;
  logic [7:0]   group_three_duty, dot_index, per_dot_current_code, dc;
  logic [7:0]   open_flag_clear, short_flag_clear;
  logic         open_flag_clear_write, short_flag_clear_write;
  logic [15:0]  dot_duty;
  ldm_grp_e     dot_group_select;
  logic [17:0]  open_led_detect, shorted_led_detect, sink_enable;
  logic [3:0]   scan_line;
  logic [287:0] sink_current;
  logic         any_open_fault_flag, any_short_fault_flag;
  logic [197:0] dot_open_flags, dot_short_flags;
  logic [1:0]   fl, dl;
  int           fails, cmp_count, n;
  ldm_note_s    note_q[$];
  ldm_note_s    nt;
  assign fl = {any_open_fault_flag, any_short_fault_flag};
  assign dl = {|dot_open_flags, |dot_short_flags};
  ldm_dimming DUT (.*);
  ldm_host_model host (.*);
  initial core_clk = 1'b0;
  always #20 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic note(input int k, input int i, input logic [15:0] v);
    note_q.push_back('{k, i, v});
  endtask
  task automatic wrap_up();
    $display("compares %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic clear(input logic [7:0] code, input logic opn);
    @(posedge core_clk);
    open_flag_clear        <= code;
    short_flag_clear       <= code;
    open_flag_clear_write  <= opn;
    short_flag_clear_write <= !opn;
    @(posedge core_clk);
    open_flag_clear_write  <= 1'b0;
    short_flag_clear_write <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  function automatic logic [15:0] exp_cur(input int s);
    logic [6:0] cc;
    cc = s % 3 == 0 ? color_one_current_code : s % 3 == 1 ?
         color_two_current_code : color_three_current_code;
    return 16'((32'(peak_current_code) * cc * dc) >> 7);
  endfunction
  always @(negedge core_clk) begin
    if (note_q.size() > 0) begin
      nt = note_q.pop_front();
      case (nt.kind)
        0: check(16'(peak_code_active), nt.val);
        1: check(16'(peak_code_active), nt.val);
        2: check(16'(any_open_fault_flag), nt.val);
        3: check(16'(any_short_fault_flag), nt.val);
        4: check(16'(fl), nt.val);
        5: check(16'(dl), nt.val);
        6: check(16'(dl), nt.val);
        7: check(sink_current[nt.idx*16 +: 16], nt.val);
        9: check(16'(nt.idx), nt.val);
        default: check(16'(nt.idx), nt.val);
      endcase
    end
  end
  initial begin
    repeat (90000) @(posedge core_clk);
    fails++;
    wrap_up();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, chip_enable, pwm_freq_low, phase_shift_enable} = 4'h8;
    {sink_on_shift_enable, gamma_scale_enable, upside_deghost_enable} = '0;
    {open_channel_cutoff_enable, shorted_line_deghost_cutoff_enable} = '0;
    refresh_mode = LDM_MODE_DIRECT;
    {peak_current_code, color_one_current_code} = '0;
    {color_two_current_code, color_three_current_code} = '0;
    {global_duty, group_one_duty, group_two_duty, group_three_duty} = '1;
    {open_flag_clear, short_flag_clear, dc} = '0;
    {open_flag_clear_write, short_flag_clear_write} = '0;
    {open_led_detect, shorted_led_detect} = '0;
    {fails, cmp_count} = '0;
    void'($urandom(84));
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    // reset value still stands until the next edge
    note(0, 0, 16'h3);
    @(posedge core_clk);
    for (int c = 0; c < 7; c++) begin
      peak_current_code <= 3'(c);
      repeat (4) @(posedge core_clk);
      note(1, 0, 16'(c));
    end
    refresh_mode <= LDM_MODE_FRAME8;
    chip_enable  <= 1'b1;
    repeat (3) @(posedge core_clk);
    peak_current_code <= 3'h2;
    repeat (4) @(posedge core_clk);
    note(1, 0, 16'h6);
    chip_enable <= 1'b0;
    repeat (4) @(posedge core_clk);
    chip_enable <= 1'b1;
    repeat (4) @(posedge core_clk);
    note(1, 0, 16'h2);
    $display("peak code test done");
    refresh_mode             <= LDM_MODE_DIRECT;
    peak_current_code        <= 3'h3;
    color_one_current_code   <= 7'($urandom % 128);
    color_two_current_code   <= 7'($urandom % 128);
    color_three_current_code <= 7'($urandom % 128);
    dc = 8'($urandom);
    host.write_all(16'h00ff, 1'b0, dc);
    for (n = 0; n < 3000 && sink_enable !== '1; n++) @(posedge core_clk);
    for (int s = 0; s < 18; s++) note(7, s, exp_cur(s));
    $display("current gain test done");
    refresh_mode       <= LDM_MODE_FRAME8;
    gamma_scale_enable <= 1'b1;
    pwm_freq_low       <= 1'b1;
    host.write_all(16'h0000, 1'b0, dc);
    for (n = 0; n < 5000 && sink_enable !== '1; n++) @(posedge core_clk);
    note(8, int'(sink_enable === '1), 16'h1);
    host.sync_pulse();
    repeat (4) @(posedge core_clk);
    n = 0;
    repeat (5000) begin
      @(posedge core_clk);
      n += int'(sink_enable != '0);
    end
    note(8, n, 16'h0);
    $display("frame sync test done");
    // duty 24 sits one below the qualifying floor: no flag may appear
    refresh_mode       <= LDM_MODE_DIRECT;
    gamma_scale_enable <= 1'b0;
    pwm_freq_low       <= 1'b0;
    {phase_shift_enable, sink_on_shift_enable} <= 2'b11;
    {open_channel_cutoff_enable, upside_deghost_enable} <= 2'b11;
    shorted_line_deghost_cutoff_enable <= 1'b1;
    host.write_all(16'h0018, 1'b0, dc);
    open_led_detect    <= 18'h15555;
    shorted_led_detect <= 18'h2aaaa;
    repeat (5 * SUB) @(posedge core_clk);
    note(2, 0, 16'h0);
    note(3, 0, 16'h0);
    host.write_all(16'h0000, 1'b1, dc);
    for (n = 0; n < 6 * SUB && fl != 2'b11; n++) @(posedge core_clk);
    note(4, 0, 16'h3);
    {open_led_detect, shorted_led_detect} <= '0;
    repeat (2 * SUB) @(posedge core_clk);
    note(4, 0, 16'h3);
    clear(8'h0e, 1'b1);
    clear(8'h0e, 1'b0);
    note(4, 0, 16'h3);
    clear(8'h0f, 1'b1);
    note(5, 0, 16'h1);
    // every line holds a shorted dot: deghost must stay off
    n = 0;
    repeat (SUB) begin
      @(posedge core_clk);
      n += int'(upside_deghost_active);
    end
    note(9, n, 16'h0);
    clear(8'h0f, 1'b0);
    note(6, 0, 16'h0);
    for (n = 0; n < 300 && upside_deghost_active !== 1'b1; n++) begin
      @(posedge core_clk);
    end
    note(9, int'(upside_deghost_active === 1'b1), 16'h1);
    $display("fault flag test done");
    while (note_q.size() > 0) @(posedge core_clk);
    wrap_up();
  end
endmodule
